/* File: csim_pkg.sv */
/*
 * csim_pkg: shared constants and carriers for the calibration source
 * and input mux block.
 * assumes: used by csim_top, csim_top_props and the bench, referenced as csim_pkg::name.
 */
package csim_pkg;

    // ---------------------------------------------------------------
    // register map (index; byte address is four times the index)
    // ---------------------------------------------------------------
    localparam logic [7:0] CAL_CFG_IDX = 8'h12;
    localparam logic [7:0] MUX_CFG_IDX = 8'h14;
    localparam logic [7:0] STATUS_IDX = 8'h13;
    localparam logic [23:0] CAL_CFG_RST = 24'h00_4800;
    localparam logic [23:0] MUX_CFG_RST = 24'h30_0000;
    localparam logic [23:0] CAL_CFG_MASK = 24'h70_7FFF;
    localparam logic [23:0] MUX_CFG_MASK = 24'hBF_0000;

    // ---------------------------------------------------------------
    // field positions
    // ---------------------------------------------------------------
    localparam int CAL_ON_BIT = 22;
    localparam int SWING_BIT = 21;
    localparam int AMP_BIT = 20;
    localparam int FREQ_LSB = 12;
    localparam int HALF_BIT = 11;
    localparam int INVERT_BIT = 23;
    localparam int POS_ISO_BIT = 21;
    localparam int NEG_ISO_BIT = 20;
    localparam int POS_ROUTE_LSB = 18;
    localparam int NEG_ROUTE_LSB = 16;

    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int BASE_CLOCK_HZ = 32768;
    localparam int DIV_BASE_LOG2 = 7;
    // phase increments, 16-bit fraction of the base clock rate
    localparam logic [16:0] INC_32768 = 17'h1_0000;
    localparam logic [16:0] INC_32000 = 17'h0_FA00;
    localparam logic [16:0] INC_31969 = 17'h0_F9C2;

    // ---------------------------------------------------------------
    // carriers
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        LVL_OFF, LVL_MID, LVL_PLUS, LVL_MINUS
    } csim_level_e;

    typedef enum logic [1:0] {
        ROUTE_NONE, ROUTE_MID, ROUTE_CAL_POS, ROUTE_CAL_NEG
    } csim_route_e;

    typedef struct packed {
        csim_level_e level;
        logic half_mv;
    } csim_cal_s;

    typedef struct packed {
        logic connect;
        csim_route_e route;
    } csim_input_s;

endpackage : csim_pkg

/* File: csim_top.sv */
/*
 * csim_top: calibration square-wave source and electrode input mux
 * configuration, with an APB slave for the two config registers.
 * assumes: clk at 50 MHz; base_input_clock is an asynchronous 32.768 kHz
 * pin; master_rate_select comes from a neighbouring register on clk.
 */
// Added by the designer: the APB interface to the registers.
// Notes on behaviour
// - calibration output levels and cal routes live only while cal_source_on is one.
// - swing select zero toggles between mid and mid offset by magnitude.
// - swing select one toggles between mid plus and mid minus magnitude.
// - amplitude select zero gives 0.25mV, one gives 0.50mV.
// - frequency code picks master divided by 128 up to 2^21.
// - calibration frequency follows the selected master rate.
// - half duty select one gives 50% high, high time ignored.
// - half duty select zero uses the eleven-bit high time.
// - high time equals field value times calibration time step.
// - time step is one master period, derived from master rate select.
// - input invert bit inverts the electrode input polarity.
// - positive isolate one disconnects positive electrode, default one.
// - negative isolate one disconnects negative electrode, default one.
// - positive route: none, mid, cal pos, cal neg; cal codes need on.
// - negative route uses same code; cal codes need cal source on.
// - calibration outputs can be steered onto channel inputs.
// - master frequency always derived from the 32.768 kHz base clock.
// - time step 30.52, 31.25, 31.25, 31.28 us for rate codes 0-3.
`timescale 1ns/10ps
`default_nettype none

module csim_top #(
    parameter int CNT_W = 21,
    parameter int HIGH_W = 11
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [9:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // timing sources
    input wire logic base_input_clock,
    input wire logic [1:0] master_rate_select,
    // calibration outputs
    output csim_pkg::csim_cal_s cal_out_pos,
    output csim_pkg::csim_cal_s cal_out_neg,
    // input mux controls
    output logic input_invert,
    output csim_pkg::csim_input_s pos_input,
    output csim_pkg::csim_input_s neg_input
);

    if (CNT_W < 21 || HIGH_W != 11) begin : g_check
        $error("csim_top: counter must hold 2^21, high time is 11 bits");
    end

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    function automatic logic [CNT_W:0] period_of(input logic [2:0] code);
        logic [CNT_W:0] one;
        one = (CNT_W + 1)'(1);
        period_of = one << (csim_pkg::DIV_BASE_LOG2 + 32'(code) * 2);
    endfunction : period_of

    function automatic csim_pkg::csim_route_e route_of(
        input logic [1:0] code,
        input logic on
    );
        route_of = csim_pkg::csim_route_e'(code);
        if (code[1] && !on) begin
            route_of = csim_pkg::ROUTE_NONE;
        end
    endfunction : route_of

    // ---------------------------------------------------------------
    // config registers and apb slave
    // ---------------------------------------------------------------
    logic [23:0] cal_cfg_reg, cal_cfg_next;
    logic [23:0] mux_cfg_reg, mux_cfg_next;
    logic [31:0] prdata_reg, prdata_next;
    logic pready_reg, pready_next;
    logic pslverr_reg, pslverr_next;
    logic cal_high_reg;
    logic [7:0] idx;
    logic hit;

    always_comb begin
        idx = paddr[9:2];
        hit = (paddr[1:0] == 2'b00) &&
              (idx == csim_pkg::CAL_CFG_IDX ||
               idx == csim_pkg::MUX_CFG_IDX ||
               idx == csim_pkg::STATUS_IDX);
        cal_cfg_next = cal_cfg_reg;
        mux_cfg_next = mux_cfg_reg;
        prdata_next = prdata_reg;
        pslverr_next = 1'b0;
        // answer one cycle into the access phase
        pready_next = psel && penable && !pready_reg;
        if (psel && penable && !pready_reg) begin
            pslverr_next = !hit;
            prdata_next = 32'h0000_0000;
            if (!pwrite && idx == csim_pkg::CAL_CFG_IDX) begin
                prdata_next = {8'h00, cal_cfg_reg};
            end else if (!pwrite && idx == csim_pkg::MUX_CFG_IDX) begin
                prdata_next = {8'h00, mux_cfg_reg};
            end else if (!pwrite && idx == csim_pkg::STATUS_IDX) begin
                prdata_next = {31'h0000_0000, cal_high_reg};
            end
        end
        if (psel && penable && pready_reg && pwrite && !pslverr_reg) begin
            if (idx == csim_pkg::CAL_CFG_IDX) begin
                cal_cfg_next = pwdata[23:0] & csim_pkg::CAL_CFG_MASK;
            end
            if (idx == csim_pkg::MUX_CFG_IDX) begin
                mux_cfg_next = pwdata[23:0] & csim_pkg::MUX_CFG_MASK;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cal_cfg_reg <= csim_pkg::CAL_CFG_RST;
            mux_cfg_reg <= csim_pkg::MUX_CFG_RST;
            prdata_reg <= 32'h0000_0000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            cal_cfg_reg <= cal_cfg_next;
            mux_cfg_reg <= mux_cfg_next;
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;

    // ---------------------------------------------------------------
    // base clock capture and master tick
    // ---------------------------------------------------------------
    logic [2:0] sync_reg, sync_next;
    logic base_lvl_reg, base_lvl_next;
    logic [16:0] phase_reg, phase_next;
    logic master_tick;
    logic base_rise;
    logic [16:0] inc;
    logic [17:0] sum;

    always_comb begin
        sync_next = {sync_reg[1:0], base_input_clock};
        base_lvl_next = base_lvl_reg;
        if (sync_reg[1] == sync_reg[2]) begin
            base_lvl_next = sync_reg[2];
        end
        base_rise = base_lvl_next && !base_lvl_reg;
        // every master tick comes from a base edge
        case (master_rate_select)
            2'b00: inc = csim_pkg::INC_32768;
            2'b01: inc = csim_pkg::INC_32000;
            2'b10: inc = csim_pkg::INC_32000;
            2'b11: inc = csim_pkg::INC_31969;
            default: inc = csim_pkg::INC_32768;
        endcase
        sum = {1'b0, phase_reg} + {1'b0, inc};
        phase_next = phase_reg;
        master_tick = 1'b0;
        if (base_rise) begin
            phase_next = {1'b0, sum[15:0]};
            master_tick = sum[16];
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sync_reg <= 3'b000;
            base_lvl_reg <= 1'b0;
            phase_reg <= 17'h0_0000;
        end else begin
            sync_reg <= sync_next;
            base_lvl_reg <= base_lvl_next;
            phase_reg <= phase_next;
        end
    end

    // ---------------------------------------------------------------
    // calibration waveform
    // ---------------------------------------------------------------
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic cal_high_next;
    logic cal_on;
    logic [CNT_W:0] period;
    logic [CNT_W:0] high_len;
    logic [HIGH_W-1:0] high_time;

    always_comb begin
        cal_on = cal_cfg_reg[csim_pkg::CAL_ON_BIT];
        high_time = cal_cfg_reg[HIGH_W-1:0];
        period = period_of(cal_cfg_reg[csim_pkg::FREQ_LSB +: 3]);
        if (cal_cfg_reg[csim_pkg::HALF_BIT]) begin
            high_len = period >> 1;
        end else begin
            high_len = (CNT_W + 1)'(high_time);
        end
        cnt_next = cnt_reg;
        if (!cal_on) begin
            cnt_next = '0;
        end else if (master_tick) begin
            if ({1'b0, cnt_reg} >= period - 1'b1) begin
                cnt_next = '0;
            end else begin
                cnt_next = cnt_reg + 1'b1;
            end
        end
        cal_high_next = cal_on && ({1'b0, cnt_next} < high_len);
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cnt_reg <= '0;
            cal_high_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            cal_high_reg <= cal_high_next;
        end
    end

    // ---------------------------------------------------------------
    // output levels and input mux
    // ---------------------------------------------------------------
    csim_pkg::csim_cal_s pos_next, neg_next;
    csim_pkg::csim_cal_s pos_reg, neg_reg;
    csim_pkg::csim_input_s pin_next, nin_next;
    csim_pkg::csim_input_s pin_reg, nin_reg;
    logic inv_reg;

    always_comb begin
        pos_next.half_mv = cal_cfg_reg[csim_pkg::AMP_BIT];
        neg_next.half_mv = cal_cfg_reg[csim_pkg::AMP_BIT];
        pos_next.level = csim_pkg::LVL_OFF;
        neg_next.level = csim_pkg::LVL_OFF;
        if (cal_cfg_reg[csim_pkg::CAL_ON_BIT]) begin
            if (cal_cfg_reg[csim_pkg::SWING_BIT]) begin
                pos_next.level = cal_high_next ? csim_pkg::LVL_PLUS
                                               : csim_pkg::LVL_MINUS;
                neg_next.level = cal_high_next ? csim_pkg::LVL_MINUS
                                               : csim_pkg::LVL_PLUS;
            end else begin
                pos_next.level = cal_high_next ? csim_pkg::LVL_PLUS
                                               : csim_pkg::LVL_MID;
                neg_next.level = cal_high_next ? csim_pkg::LVL_MINUS
                                               : csim_pkg::LVL_MID;
            end
        end
        pin_next.connect = !mux_cfg_reg[csim_pkg::POS_ISO_BIT];
        nin_next.connect = !mux_cfg_reg[csim_pkg::NEG_ISO_BIT];
        pin_next.route = route_of(mux_cfg_reg[csim_pkg::POS_ROUTE_LSB +: 2],
                                  cal_cfg_reg[csim_pkg::CAL_ON_BIT]);
        nin_next.route = route_of(mux_cfg_reg[csim_pkg::NEG_ROUTE_LSB +: 2],
                                  cal_cfg_reg[csim_pkg::CAL_ON_BIT]);
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pos_reg <= '{level: csim_pkg::LVL_OFF, half_mv: 1'b0};
            neg_reg <= '{level: csim_pkg::LVL_OFF, half_mv: 1'b0};
            pin_reg <= '{connect: 1'b0, route: csim_pkg::ROUTE_NONE};
            nin_reg <= '{connect: 1'b0, route: csim_pkg::ROUTE_NONE};
            inv_reg <= 1'b0;
        end else begin
            pos_reg <= pos_next;
            neg_reg <= neg_next;
            pin_reg <= pin_next;
            nin_reg <= nin_next;
            inv_reg <= mux_cfg_reg[csim_pkg::INVERT_BIT];
        end
    end

    assign cal_out_pos = pos_reg;
    assign cal_out_neg = neg_reg;
    assign pos_input = pin_reg;
    assign neg_input = nin_reg;
    assign input_invert = inv_reg;

endmodule : csim_top

`default_nettype wire

/* File: csim_top_props.sv */
/*
 * csim_top_props: port-level checks of csim_top.
 * assumes: bound to every csim_top instance by the bind below.
 */
`timescale 1ns/10ps
`default_nettype none

module csim_top_props (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [9:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // calibration outputs
    input wire csim_pkg::csim_cal_s cal_out_pos,
    input wire csim_pkg::csim_cal_s cal_out_neg
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    property p_one_wait;
        $rose(penable) && psel |-> !pready ##1 pready;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("wait state wrong");
    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready long");
    property p_ready_access;
        pready |-> psel && penable && $past(penable);
    endproperty
    a_ready_access: assert property (p_ready_access) else $error("stray pready");
    property p_err_align;
        pready && paddr[1:0] != 2'b00 |-> pslverr;
    endproperty
    a_err_align: assert property (p_err_align) else $error("misaligned ok");
    property p_read_upper;
        pready && !pwrite |-> prdata[31:24] == 8'h00;
    endproperty
    a_read_upper: assert property (p_read_upper) else $error("upper bits set");
    property p_off_pair;
        (cal_out_pos.level == csim_pkg::LVL_OFF)
            == (cal_out_neg.level == csim_pkg::LVL_OFF);
    endproperty
    a_off_pair: assert property (p_off_pair) else $error("off mismatch");
    property p_plus_pair;
        cal_out_pos.level == csim_pkg::LVL_PLUS
            |-> cal_out_neg.level == csim_pkg::LVL_MINUS;
    endproperty
    a_plus_pair: assert property (p_plus_pair) else $error("neg not minus");
    property p_mid_pair;
        cal_out_pos.level == csim_pkg::LVL_MID
            |-> cal_out_neg.level == csim_pkg::LVL_MID;
    endproperty
    a_mid_pair: assert property (p_mid_pair) else $error("neg not mid");
    property p_amp_pair;
        cal_out_pos.half_mv == cal_out_neg.half_mv;
    endproperty
    a_amp_pair: assert property (p_amp_pair) else $error("amp mismatch");
endmodule : csim_top_props

bind csim_top csim_top_props u_props (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cal_out_pos(cal_out_pos), .cal_out_neg(cal_out_neg)
);

`default_nettype wire

/* File: test_csim_top.sv */
/*
 * test_csim_top: self-checking bench of csim_top.
 * assumes: csim_pkg and the checker compiled first.
 */
`timescale 1ns/10ps
`default_nettype none

module test_csim_top;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [9:0] paddr = 10'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic base_input_clock = 1'b0;
    logic [1:0] master_rate_select = 2'h0;
    csim_pkg::csim_cal_s cal_out_pos;
    csim_pkg::csim_cal_s cal_out_neg;
    logic input_invert;
    csim_pkg::csim_input_s pos_input;
    csim_pkg::csim_input_s neg_input;
    int err_count = 0;
    int total_checks = 0;
    int cycles = 0;
    logic [31:0] rd;
    logic er;

    csim_top dut (
        .clk(clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .base_input_clock(base_input_clock),
        .master_rate_select(master_rate_select),
        .cal_out_pos(cal_out_pos), .cal_out_neg(cal_out_neg),
        .input_invert(input_invert), .pos_input(pos_input),
        .neg_input(neg_input)
    );

    // -----------------------------------------------------------------
    // clocks and timeout
    // -----------------------------------------------------------------
    always #10 clk = ~clk;
    // base pin: one master tick every 8 clk
    always begin
        repeat (4) @(posedge clk);
        base_input_clock <= ~base_input_clock;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            err_count++;
            print_verdict();
        end
    end

    // -----------------------------------------------------------------
    // helpers
    // -----------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [9:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // wait for the answer; only the bench timeout ends a hang
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1);
        // one wait state: pready seen at the second access edge
        chk("ready_wait", 32'h0000_0002, 32'(n));
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // -----------------------------------------------------------------
    // scenarios
    // -----------------------------------------------------------------
    task automatic t_regs();
        apb(1'b0, 10'h048, 32'h0000_0000);
        chk("cal_rst", 32'h0000_4800, rd);
        apb(1'b0, 10'h050, 32'h0000_0000);
        chk("mux_rst", 32'h0030_0000, rd);
        chk("pos_rst", 32'h0000_0000, {29'h0, pos_input});
        apb(1'b0, 10'h04C, 32'h0000_0000);
        chk("status_off", 32'h0000_0000, rd);
        chk("ok_resp", 32'h0000_0000, {31'h0, er});
        apb(1'b1, 10'h048, 32'hFFFF_FFFF);
        apb(1'b0, 10'h048, 32'h0000_0000);
        chk("cal_mask", 32'h0070_7FFF, rd);
        apb(1'b1, 10'h050, 32'hFFFF_FFFF);
        apb(1'b0, 10'h050, 32'h0000_0000);
        chk("mux_mask", 32'h00BF_0000, rd);
        apb(1'b1, 10'h3FC, 32'h0000_0000);
        chk("unmapped", 32'h0000_0001, {31'h0, er});
        apb(1'b0, 10'h049, 32'h0000_0000);
        chk("misalign", 32'h0000_0001, {31'h0, er});
        apb(1'b1, 10'h048, 32'h0000_0000);
        apb(1'b1, 10'h050, 32'h0030_0000);
    endtask : t_regs

    task automatic t_mux();
        apb(1'b1, 10'h050, 32'h00BB_0000);
        repeat (2) @(posedge clk);
        chk("invert", 32'h0000_0001, {31'h0, input_invert});
        chk("pos_gated", 32'h0000_0000, {29'h0, pos_input});
        chk("neg_gated", 32'h0000_0000, {29'h0, neg_input});
        apb(1'b1, 10'h048, 32'h0040_4800);
        repeat (2) @(posedge clk);
        chk("pos_cal", 32'h0000_0002, {29'h0, pos_input});
        chk("neg_cal", 32'h0000_0003, {29'h0, neg_input});
        apb(1'b1, 10'h050, 32'h0024_0000);
        repeat (2) @(posedge clk);
        chk("pos_iso_mid", 32'h0000_0001, {29'h0, pos_input});
        chk("neg_conn", 32'h0000_0004, {29'h0, neg_input});
        chk("no_invert", 32'h0000_0000, {31'h0, input_invert});
        apb(1'b1, 10'h050, 32'h0010_0000);
        repeat (2) @(posedge clk);
        chk("pos_conn", 32'h0000_0004, {29'h0, pos_input});
        chk("neg_iso", 32'h0000_0000, {29'h0, neg_input});
    endtask : t_mux

    // one 128-tick period is 1024 clk; counts are clk cycles per level
    task automatic t_waves();
        // last entry: code 1, 512 ticks (4096 clk), 300 ticks high
        logic [23:0] cfg [7] = '{24'h40_0800, 24'h70_0800, 24'h40_000A,
                                 24'h40_007F, 24'h40_0000, 24'h00_0800,
                                 24'h40_112C};
        int ep [7] = '{512, 512, 80, 1016, 0, 0, 2400};
        int em [7] = '{512, 0, 944, 8, 1024, 0, 1696};
        int en [7] = '{0, 512, 0, 0, 0, 0, 0};
        int wn [7] = '{1024, 1024, 1024, 1024, 1024, 1024, 4096};
        int np;
        int nm;
        int nn;
        int nq;
        for (int k = 0; k < 7; k++) begin
            apb(1'b1, 10'h048, {8'h00, cfg[k]});
            repeat (1100) @(posedge clk);
            np = 0;
            nm = 0;
            nn = 0;
            nq = 0;
            repeat (wn[k]) begin
                @(posedge clk);
                np += int'(cal_out_pos.level === csim_pkg::LVL_PLUS);
                nm += int'(cal_out_pos.level === csim_pkg::LVL_MID);
                nn += int'(cal_out_pos.level === csim_pkg::LVL_MINUS);
                nq += int'(cal_out_neg.level === csim_pkg::LVL_MINUS);
            end
            chk("high_cnt", 32'(ep[k]), 32'(np));
            chk("mid_cnt", 32'(em[k]), 32'(nm));
            chk("minus_cnt", 32'(en[k]), 32'(nn));
            chk("neg_minus_cnt", 32'(ep[k]), 32'(nq));
            chk("half_mv", {31'h0, cfg[k][20]},
                {31'h0, cal_out_pos.half_mv});
        end
    endtask : t_waves

    task automatic print_verdict();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : print_verdict

    initial begin
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        t_regs();
        t_mux();
        t_waves();
        print_verdict();
    end
endmodule : test_csim_top

`default_nettype wire
